// *** design/pio_pin_irq_defines.vh ***
// constants for the parallel i/o port with pin interrupt logic
// assumes a 32-bit avalon-mm register window with word-aligned byte offsets
`ifndef PIO_PIN_IRQ_DEFINES_VH
`define PIO_PIN_IRQ_DEFINES_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define OFS_DATA        6'h00
`define OFS_DIRECTION   6'h04
`define OFS_PULL_EN     6'h08
`define OFS_SLEW_EN     6'h0c
`define OFS_DRIVE_HIGH  6'h10
`define OFS_IRQ_SC      6'h14
`define OFS_IRQ_PIN_SEL 6'h18
`define OFS_EDGE_POL    6'h1c
`define OFS_POWER_SC    6'h20

// ************************************************************
// field positions in the irq status/control register
// ************************************************************
`define SC_MODE_BIT     0
`define SC_ENABLE_BIT   1
`define SC_ACK_BIT      2
`define SC_FLAG_BIT     3

// ************************************************************
// field positions in the power status/control register
// ************************************************************
`define PW_PARTIAL_BIT  0
`define PW_ACK_BIT      2
`define PW_FLAG_BIT     3

// ************************************************************
// reset values (per pin bit replicated by the module)
// ************************************************************
`define RST_DIRECTION   1'b0
`define RST_PULL_EN     1'b0
`define RST_SLEW_EN     1'b1
`define RST_DRIVE_HIGH  1'b0

`endif

// *** design/pio_pin_irq.v ***
// one parallel i/o port: data, direction, pad controls, pin interrupt and stop retention
// assumes an avalon-mm master on I_CLK, pad pins asynchronous to I_CLK,
// and peripheral enables/data that come from logic on I_CLK
//
// Contract
// [R1] enabled peripheral takes pin, gpio disabled
// [R2] reset: inputs, slew on, low drive, pulls off
// [R3] direction enables output, selects data read source
// [R4] input buffer on unless analog or output-only
// [R5] digital function drives buffer; direction selects read
// [R6] analog disables both buffers; input reads zero
// [R7] analog wins over digital function
// [R8] pull enable active, off for outputs/analog
// [R9] slew bit limits transitions, none on inputs
// [R10] drive bit selects high output drive
// [R11] pin interrupts also wake from stop/wait
// [R12] per-pin select enables interrupt source
// [R13] port mode bit; per-pin polarity bit
// [R14] edges from consecutive bus-clock samples
// [R15] deasserted level seen before edge recognized
// [R16] edge/level sets flag; enable gates request
// [R17] ack write clears flag; level mode conditional
// [R18] level mode: asserted pin keeps flag set
// [R19] polarity picks pull-up or pull-down
// [R20] software init order for pin interrupts
// [R21] stop modes keep i/o state
// [R22] software checks recovery flag after stop
// [R23] ack write clears recovery flag
// [R24] pins registered; request is flag and enable
`timescale 1ns/100ps
`default_nettype none
`include "pio_pin_irq_defines.vh"

module pio_pin_irq #(
  parameter              WIDTH       = 8,
  parameter [WIDTH-1:0]  OUTPUT_ONLY = 8'h00
) (
  input  wire              I_CLK,
  input  wire              I_RST_N,
  input  wire [5:0]        I_AVS_ADDRESS,
  input  wire              I_AVS_READ,
  input  wire              I_AVS_WRITE,
  input  wire [31:0]       I_AVS_WRITEDATA,
  output wire [31:0]       O_AVS_READDATA,
  output wire              O_AVS_WAITREQUEST,
  input  wire [WIDTH-1:0]  I_PIN,
  output wire [WIDTH-1:0]  O_PIN_OUT,
  output wire [WIDTH-1:0]  O_PIN_OE,
  output wire [WIDTH-1:0]  O_IBUF_EN,
  output wire [WIDTH-1:0]  O_PULL_EN,
  output wire [WIDTH-1:0]  O_PULL_DOWN,
  output wire [WIDTH-1:0]  O_SLEW_EN,
  output wire [WIDTH-1:0]  O_DRIVE_HIGH,
  input  wire [WIDTH-1:0]  I_DIG_EN,
  input  wire [WIDTH-1:0]  I_DIG_OE,
  input  wire [WIDTH-1:0]  I_DIG_OUT,
  input  wire [WIDTH-1:0]  I_ANA_EN,
  output wire [WIDTH-1:0]  O_PERIPH_IN,
  input  wire              I_STOP,
  output wire              O_STOP_PARTIAL,
  output wire              O_IRQ,
  output wire              O_WAKE
);

  // ************************************************************
  // helpers
  // ************************************************************
  // polarity 1 means rising/high is the asserted level
  function [WIDTH-1:0] asserted_lvl;
    input [WIDTH-1:0] lvl;
    input [WIDTH-1:0] pol;
    begin
      asserted_lvl = ~(lvl ^ pol);
    end
  endfunction

  function [31:0] zext;
    input [WIDTH-1:0] v;
    begin
      zext = 32'h0000_0000;
      zext[WIDTH-1:0] = v;
    end
  endfunction

  // address compare helper, used by the irq and power ack write strobes
  function addr_is;
    input [5:0] a;
    input [5:0] ofs;
    begin
      addr_is = (a == ofs);
    end
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  reg  [WIDTH-1:0] data_q;
  reg  [WIDTH-1:0] dir_q;
  reg  [WIDTH-1:0] pull_en_q;
  reg  [WIDTH-1:0] slew_q;
  reg  [WIDTH-1:0] drive_q;
  reg  [WIDTH-1:0] irq_sel_q;
  reg  [WIDTH-1:0] pol_q;
  reg              level_mode_q;
  reg              irq_en_q;
  reg              irq_flag_q;
  reg              partial_q;
  reg              recovered_q;
  reg              stop_q;
  reg  [WIDTH-1:0] meta_q;
  reg  [WIDTH-1:0] sync_q;
  reg  [WIDTH-1:0] deassert_prev_q;
  reg              ack_q;
  reg  [31:0]      rdata_q;
  reg  [WIDTH-1:0] pad_out_q;
  reg  [WIDTH-1:0] pad_oe_q;
  reg  [WIDTH-1:0] pad_ibuf_q;
  reg  [WIDTH-1:0] pad_pull_q;
  reg  [WIDTH-1:0] pad_pdn_q;
  reg  [WIDTH-1:0] pad_slew_q;
  reg  [WIDTH-1:0] pad_drive_q;
  reg              wake_q;

  // ************************************************************
  // pin synchroniser
  // ************************************************************
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= I_PIN;
      sync_q <= meta_q;  // R24
    end
  end

  // ************************************************************
  // pad function mux
  // ************************************************************
  // analog beats digital, digital beats the port's own direction
  wire [WIDTH-1:0] ana_own  = I_ANA_EN;                      // R7
  wire [WIDTH-1:0] dig_own  = I_DIG_EN & ~I_ANA_EN;          // R1 R7
  wire [WIDTH-1:0] oe_d     = ~ana_own & ((dig_own & I_DIG_OE) | (~I_DIG_EN & dir_q));  // R3 R5 R6
  wire [WIDTH-1:0] out_d    = dig_own & I_DIG_OUT | ~I_DIG_EN & data_q;                 // R1 R5
  wire [WIDTH-1:0] ibuf_d   = ~ana_own & ~OUTPUT_ONLY;       // R4 R6
  wire [WIDTH-1:0] pull_d   = pull_en_q & ~oe_d & ~ana_own;  // R8
  wire [WIDTH-1:0] pdn_d    = pull_d & irq_sel_q & pol_q;    // R19
  // gated by the pad's own enable so logic and pad change function together
  wire [WIDTH-1:0] pin_seen = sync_q & pad_ibuf_q;           // R6
  // read source follows direction even when a peripheral owns the pin
  wire [WIDTH-1:0] data_rd  = (dir_q & data_q) | (~dir_q & pin_seen);  // R3 R5 R6

  // stop freezes the pad controls so the pins keep their pre-stop state
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pad_out_q   <= {WIDTH{1'b0}};
      pad_oe_q    <= {WIDTH{`RST_DIRECTION}};
      pad_ibuf_q  <= ~OUTPUT_ONLY;
      pad_pull_q  <= {WIDTH{`RST_PULL_EN}};
      pad_pdn_q   <= {WIDTH{1'b0}};
      pad_slew_q  <= {WIDTH{`RST_SLEW_EN}};
      pad_drive_q <= {WIDTH{`RST_DRIVE_HIGH}};
    end else if (!I_STOP) begin  // R21
      pad_out_q   <= out_d;
      pad_oe_q    <= oe_d;
      pad_ibuf_q  <= ibuf_d;
      pad_pull_q  <= pull_d;
      pad_pdn_q   <= pdn_d;
      pad_slew_q  <= slew_q & oe_d;   // R9
      pad_drive_q <= drive_q & oe_d;  // R10
    end
  end

  // ************************************************************
  // pad outputs
  // ************************************************************
  assign O_PIN_OUT    = pad_out_q;
  assign O_PIN_OE     = pad_oe_q;
  assign O_IBUF_EN    = pad_ibuf_q;
  assign O_PULL_EN    = pad_pull_q;
  assign O_PULL_DOWN  = pad_pdn_q;
  assign O_SLEW_EN    = pad_slew_q;
  assign O_DRIVE_HIGH = pad_drive_q;
  assign O_PERIPH_IN  = pin_seen;

  // ************************************************************
  // pin interrupt detection
  // ************************************************************
  wire [WIDTH-1:0] asserted_now = asserted_lvl(pin_seen, pol_q) & irq_sel_q;  // R12 R13
  wire [WIDTH-1:0] deasserted   = ~asserted_lvl(pin_seen, pol_q) & irq_sel_q;
  // an edge needs a deasserted sample from an enabled pin the cycle before
  wire [WIDTH-1:0] edge_hit     = asserted_now & deassert_prev_q;  // R14 R15
  wire             any_asserted = |asserted_now;
  // the level term sets the flag again each cycle, which is what refuses an ack
  wire             irq_event    = (|edge_hit) | (level_mode_q & any_asserted);  // R13 R16

  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      deassert_prev_q <= {WIDTH{1'b0}};
    end else begin
      deassert_prev_q <= deasserted;  // R14 R15
    end
  end

  // ************************************************************
  // avalon-mm slave: one wait state per access
  // ************************************************************
  // a fixed wait state lets read data come from a flop at no cost in decode timing
  wire bus_req = I_AVS_READ | I_AVS_WRITE;
  wire wr_go   = I_AVS_WRITE & ack_q;
  wire [WIDTH-1:0] wdata = I_AVS_WRITEDATA[WIDTH-1:0];

  assign O_AVS_WAITREQUEST = bus_req & ~ack_q;
  assign O_AVS_READDATA    = rdata_q;

  wire irq_ack_wr = wr_go && addr_is(I_AVS_ADDRESS, `OFS_IRQ_SC) && I_AVS_WRITEDATA[`SC_ACK_BIT];
  wire pw_ack_wr  = wr_go && addr_is(I_AVS_ADDRESS, `OFS_POWER_SC) && I_AVS_WRITEDATA[`PW_ACK_BIT];
  // level mode refuses the clear while any enabled pin is asserted
  wire flag_clr   = irq_ack_wr & ~(level_mode_q & any_asserted);  // R17 R18

  // ************************************************************
  // read data capture
  // ************************************************************
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (I_AVS_ADDRESS)
      `OFS_DATA:        rd_mux = zext(data_rd);
      `OFS_DIRECTION:   rd_mux = zext(dir_q);
      `OFS_PULL_EN:     rd_mux = zext(pull_en_q);
      `OFS_SLEW_EN:     rd_mux = zext(slew_q);
      `OFS_DRIVE_HIGH:  rd_mux = zext(drive_q);
      `OFS_IRQ_SC: begin
        rd_mux[`SC_MODE_BIT]   = level_mode_q;
        rd_mux[`SC_ENABLE_BIT] = irq_en_q;
        rd_mux[`SC_FLAG_BIT]   = irq_flag_q;
      end
      `OFS_IRQ_PIN_SEL: rd_mux = zext(irq_sel_q);
      `OFS_EDGE_POL:    rd_mux = zext(pol_q);
      `OFS_POWER_SC: begin
        rd_mux[`PW_PARTIAL_BIT] = partial_q;
        rd_mux[`PW_FLAG_BIT]    = recovered_q;
      end
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // read data is latched in the first cycle and holds until the next read
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (I_AVS_READ && !ack_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      data_q       <= {WIDTH{1'b0}};
      dir_q        <= {WIDTH{`RST_DIRECTION}};   // R2
      pull_en_q    <= {WIDTH{`RST_PULL_EN}};     // R2
      slew_q       <= {WIDTH{`RST_SLEW_EN}};     // R2
      drive_q      <= {WIDTH{`RST_DRIVE_HIGH}};  // R2
      irq_sel_q    <= {WIDTH{1'b0}};
      pol_q        <= {WIDTH{1'b0}};
      level_mode_q <= 1'b0;
      irq_en_q     <= 1'b0;
      partial_q    <= 1'b0;
    end else if (wr_go) begin
      case (I_AVS_ADDRESS)
        `OFS_DATA:        data_q    <= wdata;
        `OFS_DIRECTION:   dir_q     <= wdata;
        `OFS_PULL_EN:     pull_en_q <= wdata;
        `OFS_SLEW_EN:     slew_q    <= wdata;
        `OFS_DRIVE_HIGH:  drive_q   <= wdata;
        `OFS_IRQ_SC: begin
          level_mode_q <= I_AVS_WRITEDATA[`SC_MODE_BIT];
          irq_en_q     <= I_AVS_WRITEDATA[`SC_ENABLE_BIT];
        end
        `OFS_IRQ_PIN_SEL: irq_sel_q <= wdata;
        `OFS_EDGE_POL:    pol_q     <= wdata;
        `OFS_POWER_SC:    partial_q <= I_AVS_WRITEDATA[`PW_PARTIAL_BIT];
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // port interrupt flag: a set in the clearing cycle wins
  // ************************************************************
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_flag_q <= 1'b0;
    end else if (irq_event) begin
      irq_flag_q <= 1'b1;  // R16
    end else if (flag_clr) begin
      irq_flag_q <= 1'b0;  // R17
    end
  end

  // ************************************************************
  // partial power-down recovery flag
  // ************************************************************
  // recovery is the falling edge of stop; a set in the ack cycle wins
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      stop_q      <= 1'b0;
      recovered_q <= 1'b0;
    end else begin
      stop_q <= I_STOP;
      if (stop_q && !I_STOP && partial_q) begin
        recovered_q <= 1'b1;
      end else if (pw_ack_wr) begin
        recovered_q <= 1'b0;  // R23
      end
    end
  end

  // ************************************************************
  // wake request
  // ************************************************************
  // one pulse per event cycle; the system side stretches it if it must
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= I_STOP & irq_event & irq_en_q;  // R11
    end
  end

  assign O_IRQ          = irq_flag_q & irq_en_q;  // R16 R24
  assign O_WAKE         = wake_q;                 // R11
  assign O_STOP_PARTIAL = partial_q;              // R21

endmodule
`default_nettype wire

// *** verif/pio_pin_irq_checker.sv ***
// port rule checker for pio_pin_irq
// assumes the master holds each request until waitrequest falls
`timescale 1ns/100ps
`default_nettype none
module pio_pin_irq_checker #(
  parameter             WIDTH       = 8,
  parameter [WIDTH-1:0] OUTPUT_ONLY = 8'h00
) (
  input wire logic             I_CLK,
  input wire logic             I_RST_N,
  input wire logic             I_AVS_READ,
  input wire logic             I_AVS_WRITE,
  input wire logic             O_AVS_WAITREQUEST,
  input wire logic [WIDTH-1:0] O_PIN_OUT,
  input wire logic [WIDTH-1:0] O_PIN_OE,
  input wire logic [WIDTH-1:0] O_IBUF_EN,
  input wire logic [WIDTH-1:0] O_PULL_EN,
  input wire logic [WIDTH-1:0] O_PULL_DOWN,
  input wire logic [WIDTH-1:0] O_SLEW_EN,
  input wire logic [WIDTH-1:0] O_DRIVE_HIGH,
  input wire logic [WIDTH-1:0] I_DIG_EN,
  input wire logic [WIDTH-1:0] I_DIG_OE,
  input wire logic [WIDTH-1:0] I_DIG_OUT,
  input wire logic [WIDTH-1:0] I_ANA_EN,
  input wire logic [WIDTH-1:0] O_PERIPH_IN,
  input wire logic             I_STOP,
  input wire logic             O_WAKE
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence one_wait;
    O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST;
  endsequence
  bus_wait_a: assert property ($rose(I_AVS_READ | I_AVS_WRITE) |-> one_wait) else $error("bus wait not one cycle");
  ana_off_a: assert property (!I_STOP |=> ((O_PIN_OE | O_IBUF_EN | O_PULL_EN) & $past(I_ANA_EN)) == '0)
    else $error("analog pin keeps a buffer");
  dig_pin_a: assert property (!I_STOP |=> (((O_PIN_OE ^ $past(I_DIG_OE))
    | (O_PIN_OE & (O_PIN_OUT ^ $past(I_DIG_OUT)))) & $past(I_DIG_EN) & ~$past(I_ANA_EN)) == '0)
    else $error("peripheral not in control");
  pull_out_a: assert property ((O_PULL_EN & O_PIN_OE) == '0) else $error("pull on an output");
  slew_drive_a: assert property ($past(I_RST_N) |-> ((O_SLEW_EN | O_DRIVE_HIGH) & ~O_PIN_OE) == '0)
    else $error("slew or drive on an input");
  pull_kind_a: assert property ((O_PULL_DOWN & ~O_PULL_EN) == '0) else $error("pull-down without pull");
  ibuf_gate_a: assert property (!I_STOP |=> ((O_PERIPH_IN & ~O_IBUF_EN) | (O_IBUF_EN & OUTPUT_ONLY)
    | (O_IBUF_EN ^ (~$past(I_ANA_EN) & ~OUTPUT_ONLY))) == '0) else $error("input buffer misused");
  wake_stop_a: assert property (O_WAKE |-> $past(I_STOP)) else $error("wake outside stop");
  stop_hold_a: assert property ($past(I_STOP) |-> $stable(O_PIN_OE) && $stable(O_PULL_EN))
    else $error("pad state moved in stop");
endmodule
bind pio_pin_irq pio_pin_irq_checker #(.WIDTH(WIDTH), .OUTPUT_ONLY(OUTPUT_ONLY)) u_chk (.I_CLK(I_CLK),
  .I_RST_N(I_RST_N), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .O_PIN_OUT(O_PIN_OUT), .O_PIN_OE(O_PIN_OE), .O_IBUF_EN(O_IBUF_EN), .O_PULL_EN(O_PULL_EN),
  .O_PULL_DOWN(O_PULL_DOWN), .O_SLEW_EN(O_SLEW_EN), .O_DRIVE_HIGH(O_DRIVE_HIGH), .I_DIG_EN(I_DIG_EN),
  .I_DIG_OE(I_DIG_OE), .I_DIG_OUT(I_DIG_OUT), .I_ANA_EN(I_ANA_EN), .O_PERIPH_IN(O_PERIPH_IN),
  .I_STOP(I_STOP), .O_WAKE(O_WAKE));
`default_nettype wire

// *** verif/pin_world.sv ***
// pad model of one port: device drive, outside drivers, pulls
// assumes the bench says per pin whether something outside drives it
`timescale 1ns/100ps
`default_nettype none
module pin_world #(
  parameter WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] pin_out,
  input  wire logic [WIDTH-1:0] pin_oe,
  input  wire logic [WIDTH-1:0] pull_en,
  input  wire logic [WIDTH-1:0] pull_down,
  input  wire logic [WIDTH-1:0] ext_en,
  input  wire logic [WIDTH-1:0] ext_val,
  output var logic  [WIDTH-1:0] pin
);
  logic [WIDTH-1:0] float_q = '0;
  // a floating pad must never look like a stable level
  always @(posedge clk) float_q <= ~float_q;
  always_comb begin
    pin = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & pull_en & ~pull_down)
      | (~pin_oe & ~ext_en & ~pull_en & float_q);
  end
endmodule
`default_nettype wire

// *** verif/tb_parallel_io_pin_interrupt.sv ***
// self-checking bench for one parallel i/o port with pin interrupts
// assumes pin_world drives the pads and the bench plays the peripherals
`timescale 1ns/100ps
`default_nettype none
`include "pio_pin_irq_defines.vh"
module tb_parallel_io_pin_interrupt;
  logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, stop = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wd = 32'h0, q, rdata;
  logic [7:0]  dg_en = 8'h00, dg_oe = 8'h00, dg_out = 8'h00, ana = 8'h00, ext_v = 8'hff, ext_e = 8'hff;
  logic [7:0]  pin, p_out, p_oe, ibuf, pull, pdn, slew, drv, per_in;
  logic        waitreq, part, irq, wake;
  integer      failures = 0, n_tests = 0, seed = 76;
  always #5 clk = ~clk;
  pio_pin_irq u_pio_pin_irq (.I_CLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
    .I_PIN(pin), .O_PIN_OUT(p_out), .O_PIN_OE(p_oe), .O_IBUF_EN(ibuf), .O_PULL_EN(pull),
    .O_PULL_DOWN(pdn), .O_SLEW_EN(slew), .O_DRIVE_HIGH(drv), .I_DIG_EN(dg_en), .I_DIG_OE(dg_oe),
    .I_DIG_OUT(dg_out), .I_ANA_EN(ana), .O_PERIPH_IN(per_in), .I_STOP(stop), .O_STOP_PARTIAL(part),
    .O_IRQ(irq), .O_WAKE(wake));
  pin_world u_pin_world (.clk(clk), .pin_out(p_out), .pin_oe(p_oe), .pull_en(pull), .pull_down(pdn),
    .ext_en(ext_e), .ext_val(ext_v), .pin(pin));
  function automatic logic [31:0] exp_data(input logic [7:0] d, l, p);
    return {24'h0, (d & l) | (~d & p)};
  endfunction
  function automatic logic [31:0] exp_sc(input logic m, e, f);
    return {28'h0, f, 1'b0, e, m};
  endfunction
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ****************
  // bus master: hold the request until waitrequest is seen low
  // ****************
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        failures++;
        final_report();
      end
    end while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic put(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic get(input logic [5:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  initial begin
    logic [7:0] dv, lv, ev;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    get(`OFS_DIRECTION, 32'h0, "dir");
    get(`OFS_SLEW_EN, 32'hff, "slew");
    get(`OFS_DRIVE_HIGH, 32'h0, "drive");
    get(`OFS_PULL_EN, 32'h0, "pull");
    put(6'h3c, 32'hff);
    get(6'h3c, 32'h0, "unmapped");
    for (int i = 0; i < 12; i++) begin
      dv = 8'($random(seed));
      lv = 8'($random(seed));
      ev = 8'($random(seed));
      ext_v <= ev;
      put(`OFS_DATA, {24'h0, lv});
      put(`OFS_DIRECTION, {24'h0, dv});
      // pad enable moves one edge later, then two synchroniser flops
      repeat (3) @(posedge clk);
      get(`OFS_DATA, exp_data(dv, lv, ev), "data");
      chk("pin", exp_data(dv, lv, ev), {24'h0, pin});
    end
    put(`OFS_DATA, 32'haa);
    put(`OFS_DIRECTION, 32'h0f);
    ana <= 8'hff;
    dg_en <= 8'hff;
    dg_oe <= 8'h3c;
    dg_out <= 8'h55;
    ext_v <= 8'hf0;
    repeat (4) @(posedge clk);
    chk("bufs", 32'h0, {24'h0, p_oe | ibuf | per_in});
    get(`OFS_DATA, 32'h0a, "data");
    ana <= 8'h00;
    repeat (4) @(posedge clk);
    chk("oe", 32'h3c, {24'h0, p_oe});
    chk("periph", 32'hd4, {24'h0, per_in});
    get(`OFS_DATA, exp_data(8'h0f, 8'haa, 8'hd4), "data");
    dg_en <= 8'h00;
    put(`OFS_DIRECTION, 32'h80);
    put(`OFS_DRIVE_HIGH, 32'h81);
    put(`OFS_PULL_EN, 32'hff);
    put(`OFS_EDGE_POL, 32'h01);
    put(`OFS_IRQ_PIN_SEL, 32'h01);
    ext_e <= 8'h00;
    repeat (4) @(posedge clk);
    chk("pads", 32'h7f808001, {pull, drv, slew, pdn});
    chk("pulled", 32'h7e, {25'h0, pin[6:0]});
    ext_e <= 8'hff;
    ext_v <= 8'hfd;
    put(`OFS_PULL_EN, 32'h0);
    put(`OFS_DIRECTION, 32'h0);
    put(`OFS_IRQ_SC, 32'h0);
    put(`OFS_EDGE_POL, 32'h02);
    put(`OFS_IRQ_PIN_SEL, 32'h03);
    put(`OFS_IRQ_SC, 32'h4);
    put(`OFS_IRQ_SC, 32'h2);
    get(`OFS_IRQ_SC, exp_sc(0, 1, 0), "sc");
    ext_v <= 8'hfc;
    repeat (4) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    put(`OFS_IRQ_SC, 32'h6);
    get(`OFS_IRQ_SC, exp_sc(0, 1, 0), "sc");
    ext_v <= 8'hfe;
    repeat (4) @(posedge clk);
    get(`OFS_IRQ_SC, exp_sc(0, 1, 1), "sc");
    put(`OFS_IRQ_SC, 32'h0);
    ext_v <= 8'hf8;
    repeat (4) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    get(`OFS_IRQ_SC, exp_sc(0, 0, 1), "sc");
    put(`OFS_IRQ_SC, 32'h4);
    put(`OFS_IRQ_PIN_SEL, 32'h04);
    repeat (4) @(posedge clk);
    get(`OFS_IRQ_SC, exp_sc(0, 0, 0), "sc");
    put(`OFS_IRQ_SC, 32'h3);
    repeat (4) @(posedge clk);
    put(`OFS_IRQ_SC, 32'h7);
    get(`OFS_IRQ_SC, exp_sc(1, 1, 1), "sc");
    ext_v <= 8'hff;
    repeat (4) @(posedge clk);
    put(`OFS_IRQ_SC, 32'h7);
    get(`OFS_IRQ_SC, exp_sc(1, 1, 0), "sc");
    put(`OFS_POWER_SC, 32'h1);
    stop <= 1'b1;
    ext_v <= 8'hfb;
    dg_en <= 8'hff;
    repeat (4) @(posedge clk);
    chk("wake", 32'h1, {31'h0, wake});
    chk("oe", 32'h0, {24'h0, p_oe});
    chk("partial", 32'h1, {31'h0, part});
    stop <= 1'b0;
    dg_en <= 8'h00;
    ext_v <= 8'hff;
    repeat (2) @(posedge clk);
    get(`OFS_POWER_SC, 32'h9, "power");
    put(`OFS_POWER_SC, 32'h5);
    get(`OFS_POWER_SC, 32'h1, "power");
    final_report();
  end
endmodule
`default_nettype wire
